// >>> hdl/udc4_regs.svh
// Purpose: Named constants for the 4-bit up/down counter
// Assumes: Included by its bare name from the package and the design modules
// Notes: Count values are sized to the 4-bit count path
`ifndef UDC4_REGS_SVH
`define UDC4_REGS_SVH

// ----------------------------------------------------------------------
// Count path
// ----------------------------------------------------------------------
`define UDC4_WIDTH 4
`define UDC4_COUNT_ZERO 4'h0
`define UDC4_COUNT_MAX 4'hF
`define UDC4_COUNT_STEP 4'h1

// ----------------------------------------------------------------------
// Levels
// ----------------------------------------------------------------------
`define UDC4_CLK_IDLE 1'b1
`define UDC4_TC_INACTIVE 1'b1

`endif

// >>> hdl/udc4_pkg.sv
// Purpose: Types shared by the 4-bit up/down counter modules
// Assumes: udc4_regs.svh supplies the widths
// Notes: Mode codes are one-hot
`include "udc4_regs.svh"

package udc4_pkg;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [`UDC4_WIDTH-1:0] udc4_count_t;

	typedef enum logic [4:0] {
		UDC4_MODE_HOLD  = 5'h01,
		UDC4_MODE_UP    = 5'h02,
		UDC4_MODE_DOWN  = 5'h04,
		UDC4_MODE_LOAD  = 5'h08,
		UDC4_MODE_CLEAR = 5'h10
	} udc4_mode_t;

endpackage

// >>> hdl/udc4_edge_detect.sv
// Purpose: Rising-edge detector for one count clock input
// Assumes: The input is synchronous to clk
// Notes: History starts at the idle-high level so reset makes no false edge
`include "udc4_regs.svh"

module udc4_edge_detect (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Sampled level and its rising edge
	input wire logic level_in,
	output logic rise
);
	import udc4_pkg::*;

	logic prev_ff;
	logic nxt_prev;

	// ------------------------------------------------------------------
	// History
	// ------------------------------------------------------------------
	// History keeps running through clear and load, so a low level held
	// across them still yields an edge afterwards
	assign nxt_prev = level_in;

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_ff <= `UDC4_CLK_IDLE;
		end else begin
			prev_ff <= nxt_prev;
		end
	end

	assign rise = level_in & ~prev_ff;

endmodule

// >>> hdl/udc4_term_count.sv
// Purpose: Carry and borrow outputs of the 4-bit up/down counter
// Assumes: Count comes from the counter register
// Notes: Outputs copy the clock levels at terminal count, so they are combinational
`include "udc4_regs.svh"

module udc4_term_count (
	// Counter state
	input udc4_pkg::udc4_count_t count,
	// Count clocks
	input wire logic up_clock,
	input wire logic down_clock,
	// Terminal count outputs
	output logic carry_out_n,
	output logic borrow_out_n
);
	import udc4_pkg::*;

	// ------------------------------------------------------------------
	// Terminal count decode
	// ------------------------------------------------------------------
	// Copying the clock lets these drive the next stage's clocks directly
	always_comb begin
		carry_out_n = `UDC4_TC_INACTIVE;
		borrow_out_n = `UDC4_TC_INACTIVE;
		if (count == `UDC4_COUNT_MAX) begin
			carry_out_n = up_clock;
		end
		if (count == `UDC4_COUNT_ZERO) begin
			borrow_out_n = down_clock;
		end
	end

endmodule

// >>> hdl/udc4_top.sv
// Purpose: Presettable 4-bit binary up/down counter with cascade outputs
// Assumes: All inputs are synchronous to clk; one count clock pulsed at a time while the other is held high
// Notes: Clear and load act at the next clk edge, the same edge that first samples them
//
// Summary of operation
// - Up clock rise with down high increments
// - Down clock rise with up high decrements
// - All four outputs change together
// - Master clear forces count to zero
// - Clear beats load, data and clocks
// - Active load copies preset inputs to count
// - Carry low while up clock low at fifteen
// - Borrow follows down clock at zero
// - Carry and borrow high otherwise
// - Carry equals up clock at all ones
// - Low clock across clear/load still counts
// - Carry and borrow clock the next stage
// - Count wraps in binary both ways
`include "udc4_regs.svh"

module udc4_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Count clocks
	input wire logic up_clock,
	input wire logic down_clock,
	// Clear and load
	input wire logic master_clear,
	input wire logic parallel_load_n,
	// Preset data
	input wire logic preset_in_0,
	input wire logic preset_in_1,
	input wire logic preset_in_2,
	input wire logic preset_in_3,
	// Count outputs
	output logic count_out_0,
	output logic count_out_1,
	output logic count_out_2,
	output logic count_out_3,
	// Cascade outputs
	output logic carry_out_n,
	output logic borrow_out_n
);
	import udc4_pkg::*;

	udc4_count_t count_ff;
	udc4_count_t nxt_count;
	udc4_count_t preset;
	udc4_mode_t mode;
	logic up_rise;
	logic down_rise;

	// ------------------------------------------------------------------
	// Bit order
	// ------------------------------------------------------------------
	assign preset = {preset_in_3, preset_in_2, preset_in_1, preset_in_0};
	assign count_out_0 = count_ff[0];
	assign count_out_1 = count_ff[1];
	assign count_out_2 = count_ff[2];
	assign count_out_3 = count_ff[3];

	// ------------------------------------------------------------------
	// Clock edges
	// ------------------------------------------------------------------
	udc4_edge_detect u_up_edge (
		.clk(clk),
		.rst(rst),
		.level_in(up_clock),
		.rise(up_rise)
	);

	udc4_edge_detect u_down_edge (
		.clk(clk),
		.rst(rst),
		.level_in(down_clock),
		.rise(down_rise)
	);

	// ------------------------------------------------------------------
	// Mode select
	// ------------------------------------------------------------------
	// An edge on a clock whose partner is not held high is ignored; the
	// driver must keep the idle clock high
	always_comb begin
		mode = UDC4_MODE_HOLD;
		if (master_clear) begin
			mode = UDC4_MODE_CLEAR;
		end else if (!parallel_load_n) begin
			mode = UDC4_MODE_LOAD;
		end else if (up_rise && down_clock && !down_rise) begin
			mode = UDC4_MODE_UP;
		end else if (down_rise && up_clock && !up_rise) begin
			mode = UDC4_MODE_DOWN;
		end
	end

	always_comb begin
		nxt_count = count_ff;
		unique case (mode)
			UDC4_MODE_HOLD: begin
				nxt_count = count_ff;
			end
			UDC4_MODE_UP: begin
				nxt_count = count_ff + `UDC4_COUNT_STEP;
			end
			UDC4_MODE_DOWN: begin
				nxt_count = count_ff - `UDC4_COUNT_STEP;
			end
			UDC4_MODE_LOAD: begin
				nxt_count = preset;
			end
			UDC4_MODE_CLEAR: begin
				nxt_count = `UDC4_COUNT_ZERO;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Count register
	// ------------------------------------------------------------------
	// One register for all bits, so the outputs never step apart
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= `UDC4_COUNT_ZERO;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// ------------------------------------------------------------------
	// Terminal count
	// ------------------------------------------------------------------
	udc4_term_count u_term (
		.count(count_ff),
		.up_clock(up_clock),
		.down_clock(down_clock),
		.carry_out_n(carry_out_n),
		.borrow_out_n(borrow_out_n)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_idle;
		!master_clear && parallel_load_n;
	endsequence

	sequence s_up_step;
		s_idle and (up_clock && !$past(up_clock) && down_clock && $past(down_clock));
	endsequence

	sequence s_down_step;
		s_idle and (down_clock && !$past(down_clock) && up_clock && $past(up_clock));
	endsequence

	sequence s_load_low_up;
		(!master_clear && !parallel_load_n && !up_clock) ##1 (s_idle and !up_clock);
	endsequence

	a_count_up_step: assert property (
		s_up_step |=> count_ff == $past(count_ff) + `UDC4_COUNT_STEP
	) else $error("count did not increment on up clock edge");

	a_count_down_step: assert property (
		s_down_step |=> count_ff == $past(count_ff) - `UDC4_COUNT_STEP
	) else $error("count did not decrement on down clock edge");

	a_count_stable: assert property (
		s_idle and (up_clock == $past(up_clock)) and (down_clock == $past(down_clock))
		|=> $stable(count_ff)
	) else $error("count changed without a clock edge");

	a_clear_zero: assert property (
		master_clear [*2] |=> count_ff == `UDC4_COUNT_ZERO && count_ff == $past(count_ff)
	) else $error("count not held at zero during clear");

	a_clear_priority: assert property (
		master_clear && !parallel_load_n && preset != `UDC4_COUNT_ZERO
		|=> count_ff == `UDC4_COUNT_ZERO
	) else $error("load won over clear");

	a_load_copy: assert property (
		!master_clear && !parallel_load_n |=> count_ff == $past(preset)
	) else $error("load did not copy preset data");

	a_carry_follow: assert property (
		count_ff == `UDC4_COUNT_MAX && !up_clock |-> !carry_out_n ##1
		(count_ff != `UDC4_COUNT_MAX || up_clock || !carry_out_n)
	) else $error("carry not low at fifteen with up clock low");

	a_borrow_follow: assert property (
		count_ff == `UDC4_COUNT_ZERO |-> borrow_out_n == down_clock
	) else $error("borrow does not follow down clock at zero");

	a_tc_idle_high: assert property (
		(count_ff != `UDC4_COUNT_MAX |-> carry_out_n) and
		(count_ff != `UDC4_COUNT_ZERO |-> borrow_out_n)
	) else $error("terminal count output low outside terminal count");

	a_carry_after_load: assert property (
		!master_clear && !parallel_load_n && preset == `UDC4_COUNT_MAX
		|=> carry_out_n == up_clock
	) else $error("carry not equal to up clock after load of fifteen");

	a_edge_after_load: assert property (
		s_load_low_up ##1 (s_idle and up_clock && down_clock && $past(down_clock))
		|=> count_ff == $past(count_ff) + `UDC4_COUNT_STEP
	) else $error("first edge after load was not counted");

	a_wrap_up: assert property (
		s_up_step and count_ff == `UDC4_COUNT_MAX |=> count_ff == `UDC4_COUNT_ZERO
	) else $error("count did not wrap from fifteen to zero");

	a_wrap_down: assert property (
		s_down_step and count_ff == `UDC4_COUNT_ZERO |=> count_ff == `UDC4_COUNT_MAX
	) else $error("count did not wrap from zero to fifteen");

	a_bit_order: assert property (
		!master_clear && !parallel_load_n |=> count_out_0 == $past(preset_in_0) &&
		count_out_3 == $past(preset_in_3)
	) else $error("preset bit order wrong");

endmodule

// >>> verification/udc4_stage_model.sv
// Purpose: Next cascaded stage, clocked by carry and borrow of the block
// Assumes: Stage clocks are sampled on clk, as the block does
// Notes: Behavioural; history starts high so reset gives no false edge
module udc4_stage_model (
	// Clock and reset
	clk,
	rst,
	// Stage clocks
	up_clock,
	down_clock,
	// Stage count
	count
);
	timeunit 1ns;
	timeprecision 100ps;
	import udc4_pkg::*;
	input wire logic clk;
	input wire logic rst;
	input wire logic up_clock;
	input wire logic down_clock;
	output udc4_count_t count;
	logic up_last_ff;
	logic down_last_ff;
	udc4_count_t count_ff;
	assign count = count_ff;
	always_ff @(posedge clk) begin
		up_last_ff <= rst | up_clock;
		down_last_ff <= rst | down_clock;
	end
	// Other clock must be high in the same sample, else the edge is ignored
	always_ff @(posedge clk) begin
		if (rst) begin
			count_ff <= 4'h0;
		end else if (up_clock && !up_last_ff && down_clock) begin
			count_ff <= count_ff + 4'h1;
		end else if (down_clock && !down_last_ff && up_clock) begin
			count_ff <= count_ff - 4'h1;
		end
	end
endmodule

// >>> verification/tb.sv
// Purpose: Self-checking bench of the 4-bit up/down counter
// Assumes: Inputs driven 1 ns after the rising edge of clk
// Notes: A second stage model watches the cascade outputs
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import udc4_pkg::*;
	logic clk, rst, up_clock, down_clock, master_clear, parallel_load_n;
	logic carry_out_n, borrow_out_n;
	udc4_count_t preset, q, high_q;
	int err_count, n_tests, cycles;
	udc4_top dut_u (.clk(clk), .rst(rst), .up_clock(up_clock), .down_clock(down_clock),
		.master_clear(master_clear), .parallel_load_n(parallel_load_n),
		.preset_in_0(preset[0]), .preset_in_1(preset[1]), .preset_in_2(preset[2]),
		.preset_in_3(preset[3]), .count_out_0(q[0]), .count_out_1(q[1]),
		.count_out_2(q[2]), .count_out_3(q[3]), .carry_out_n(carry_out_n),
		.borrow_out_n(borrow_out_n));
	udc4_stage_model stage_u (.clk(clk), .rst(rst), .up_clock(carry_out_n),
		.down_clock(borrow_out_n), .count(high_q));
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk_cnt(input udc4_count_t got, input udc4_count_t exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string m);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %b exp %b", $time, m, got, exp);
		end
	endtask
	task automatic up_pulse;
		up_clock = 1'b0;
		cyc(1);
		up_clock = 1'b1;
		cyc(1);
	endtask
	task automatic down_pulse;
		down_clock = 1'b0;
		cyc(1);
		down_clock = 1'b1;
		cyc(1);
	endtask
	task automatic test_done;
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_load;
		chk_bit(carry_out_n, 1'b1, "idle carry");
		chk_bit(borrow_out_n, 1'b1, "idle borrow");
		up_clock = 1'b0;
		parallel_load_n = 1'b0;
		for (int i = 0; i < 4; i++) begin
			preset = 4'h1 << i;
			cyc(1);
			chk_cnt(q, 4'h1 << i, "load bit");
		end
		// Loading fifteen with up low pulses carry, so the next stage counts once here
		preset = 4'hF;
		cyc(1);
		chk_cnt(q, 4'hF, "load fifteen");
		chk_bit(carry_out_n, 1'b0, "carry after load");
		preset = 4'hD;
		cyc(1);
		chk_cnt(q, 4'hD, "load");
		parallel_load_n = 1'b1;
		cyc(1);
		up_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'hE, "count after load");
		$display("test load done");
	endtask
	task automatic t_up;
		up_pulse();
		chk_cnt(q, 4'hF, "up");
		chk_bit(carry_out_n, 1'b1, "carry up high");
		up_clock = 1'b0;
		#1;
		chk_bit(carry_out_n, 1'b0, "carry low");
		cyc(1);
		up_clock = 1'b1;
		#1;
		chk_bit(carry_out_n, 1'b1, "carry back");
		cyc(1);
		chk_cnt(q, 4'h0, "wrap up");
		chk_cnt(high_q, 4'h2, "stage up");
		up_pulse();
		up_pulse();
		chk_cnt(q, 4'h2, "up to two");
		$display("test up done");
	endtask
	task automatic t_down;
		down_pulse();
		down_pulse();
		chk_cnt(q, 4'h0, "down");
		down_clock = 1'b0;
		#1;
		chk_bit(borrow_out_n, 1'b0, "borrow low");
		chk_bit(carry_out_n, 1'b1, "carry at zero");
		cyc(1);
		down_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'hF, "wrap down");
		chk_cnt(high_q, 4'h1, "stage down");
		down_pulse();
		down_pulse();
		chk_cnt(q, 4'hD, "down to d");
		$display("test down done");
	endtask
	task automatic t_refuse;
		down_clock = 1'b0;
		up_clock = 1'b0;
		cyc(1);
		up_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'hD, "up with down low");
		up_clock = 1'b0;
		cyc(1);
		down_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'hD, "down with up low");
		up_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'hE, "up after refusal");
		$display("test refuse done");
	endtask
	task automatic t_clear;
		preset = 4'hF;
		parallel_load_n = 1'b0;
		master_clear = 1'b1;
		up_clock = 1'b0;
		down_clock = 1'b0;
		cyc(1);
		up_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'h0, "clear wins");
		chk_bit(borrow_out_n, 1'b0, "borrow in clear");
		master_clear = 1'b0;
		parallel_load_n = 1'b1;
		cyc(1);
		down_clock = 1'b1;
		cyc(1);
		chk_cnt(q, 4'hF, "count after clear");
		$display("test clear done");
	endtask
	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 500) begin
			err_count++;
			test_done();
		end
	end
	initial begin
		{rst, up_clock, down_clock, master_clear, parallel_load_n} = 5'h1F;
		master_clear = 1'b0;
		preset = 4'h0;
		cyc(3);
		rst = 1'b0;
		cyc(1);
		t_load();
		t_up();
		t_down();
		t_refuse();
		t_clear();
		test_done();
	end
endmodule
